// ### hdl/safety_input_defs.vh
// Constants for the safety input qualification and reset block.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef SAFETY_INPUT_DEFS_VH
`define SAFETY_INPUT_DEFS_VH

`define CLK_FREQ_HZ      50000000
`define TICK_RATE_HZ     1000

// Register byte offsets
`define REG_CTRL         8'h00
`define REG_SAFE_HL      8'h04
`define REG_SAFE_LH      8'h08
`define REG_ONOFF_HL     8'h0C
`define REG_ONOFF_LH     8'h10
`define REG_OFF_DELAY    8'h14
`define REG_STATUS       8'h18

// Control register fields
`define CTRL_LATCH_LSB   0
`define CTRL_MUTE_LSB    8
`define CTRL_ONOFF_MAP   16
`define CTRL_MUTE_CFG    17
`define CTRL_CANCEL_KEEP 18
`define CTRL_MRST_NONMON 19
`define CTRL_SRST_NONMON 20
`define CTRL_RESET       32'h0000_0000

// Debounce windows, milliseconds
`define WIN_W            11
`define HL_MIN_MS        11'h006
`define HL_MAX_MS        11'h064
`define LH_MIN_MS        11'h00A
`define LH_MAX_MS        11'h1F4
`define MUTE_MAX_MS      11'h5DC
`define HL_DEF_MS        11'h006
`define LH_DEF_MS        11'h032
`define FIXED_DB_MS      11'h032
`define OFF_DELAY_DEF    11'h000

// Reset pulse limits, milliseconds
`define RST_MIN_MS       11'h12C
`define RST_MAX_MS       11'h7D0

`endif

// ### hdl/safety_input_debounce_reset.v
// Input qualification, output gating and reset qualification for one
// safety output. Assumes field inputs already level shifted and
// synchronous to CLOCK; configuration over classic Wishbone.
`timescale 1ns/1ps
`include "safety_input_defs.vh"

// What this block does
// - High-to-low window 6-100 ms, mute sensor inputs up to 1500 ms.
// - High-to-low window defaults to 6 ms.
// - Low-to-high window 10-500 ms, mute sensor inputs up to 1500 ms.
// - Low-to-high window defaults to 50 ms.
// - A safety input back at its old level at window end after four or more edges flags disparity and locks out.
// - Output goes off after the off delay while any controlling input is in Stop.
// - Output turns on only with all controlling inputs Run, plus reset if latched.
// - ON/OFF debounce configurable; reset, mute, cancel fixed at 50 ms.
// - After a latched input recloses, a manual reset re-enables the output.
// - ON/OFF input switches the output while all safety inputs run.
// - Unmapped ON/OFF input drives only its status output.
// - Muting is not permitted until mute enable is high when configured.
// - Cancel signal either keeps delayed output on or drops it at once.
// - Status output shows when cancel would keep the delayed output on.
// - Manual and system resets each monitored or not, monitored default.
// - Valid system reset clears lockout and restarts after reconfiguring.
// - Automatic reset inputs restore the output without operator action.
// - Monitored reset acts on falling edge of a 0.3-2 s high pulse.
// - Non-monitored reset acts once high has lasted 0.3 s.
// - Manual reset while any safety input is in Stop is ignored.
module safety_input_debounce_reset #(
    parameter N_SAFE      = 4,
    parameter TICK_CYCLES = `CLK_FREQ_HZ / `TICK_RATE_HZ
) (
    input  wire                CLOCK,
    input  wire                SRST,
    input  wire [7:0]          WB_ADR_I,
    input  wire [31:0]         WB_DAT_I,
    output reg  [31:0]         WB_DAT_O,
    input  wire                WB_WE_I,
    input  wire [3:0]          WB_SEL_I,
    input  wire                WB_STB_I,
    input  wire                WB_CYC_I,
    output reg                 WB_ACK_O,
    input  wire [N_SAFE-1:0]   SAFETY_IN,
    input  wire                ONOFF_IN,
    input  wire                MANUAL_RESET_IN,
    input  wire                MUTE_ENABLE_IN,
    input  wire                CANCEL_DELAY_IN,
    input  wire                SYSTEM_RECOVERY_IN,
    output reg                 SAFETY_OUT,
    output reg                 ONOFF_STATUS,
    output reg                 MUTE_PERMIT,
    output reg                 CANCEL_OK_STATUS,
    output reg                 LOCKOUT
);

    localparam CH_ONOFF  = N_SAFE;
    localparam CH_MRST   = N_SAFE + 1;
    localparam CH_MUTE   = N_SAFE + 2;
    localparam CH_CANCEL = N_SAFE + 3;
    localparam CH_SYSR   = N_SAFE + 4;
    localparam N_CH      = N_SAFE + 5;
    localparam W         = `WIN_W;

    function [W-1:0] clamp;
        input [W-1:0] v;
        input [W-1:0] lo;
        input [W-1:0] hi;
        begin
            if (v < lo)
                clamp = lo;
            else if (v > hi)
                clamp = hi;
            else
                clamp = v;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (sel[b])
                    merge[b*8 +: 8] = dat[b*8 +: 8];
        end
    endfunction

    // 1 ms tick
    reg  [31:0] tick_cnt_q;
    reg         tick_q;

    always @(posedge CLOCK)
    begin
        if (SRST)
        begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == TICK_CYCLES - 1)
        begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // Registers
    reg  [31:0]  ctrl_q;
    reg  [W-1:0] safe_hl_q;
    reg  [W-1:0] safe_lh_q;
    reg  [W-1:0] onoff_hl_q;
    reg  [W-1:0] onoff_lh_q;
    reg  [W-1:0] off_delay_q;
    reg  [31:0]  rd_d;
    wire [31:0]  status_w;
    wire         wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire         wb_wr  = wb_req & WB_WE_I;
    wire         ctrl_wr;

    assign ctrl_wr = wb_wr & (WB_ADR_I == `REG_CTRL);

    // Window registers keep only the low bits of the merged word
    wire [31:0]  wb_merged = merge(rd_d, WB_DAT_I, WB_SEL_I);
    wire [W-1:0] wb_win    = wb_merged[W-1:0];

    always @*
    begin
        case (WB_ADR_I)
            `REG_CTRL:      rd_d = ctrl_q;
            `REG_SAFE_HL:   rd_d = {21'h00_0000, safe_hl_q};
            `REG_SAFE_LH:   rd_d = {21'h00_0000, safe_lh_q};
            `REG_ONOFF_HL:  rd_d = {21'h00_0000, onoff_hl_q};
            `REG_ONOFF_LH:  rd_d = {21'h00_0000, onoff_lh_q};
            `REG_OFF_DELAY: rd_d = {21'h00_0000, off_delay_q};
            `REG_STATUS:    rd_d = status_w;
            default:        rd_d = 32'h0000_0000;
        endcase
    end

    // Windows are clamped on write; non-mute safety channels are cut back again at use
    always @(posedge CLOCK)
    begin
        if (SRST)
        begin
            WB_ACK_O    <= 1'b0;
            WB_DAT_O    <= 32'h0000_0000;
            ctrl_q      <= `CTRL_RESET;
            safe_hl_q   <= `HL_DEF_MS;
            safe_lh_q   <= `LH_DEF_MS;
            onoff_hl_q  <= `HL_DEF_MS;
            onoff_lh_q  <= `LH_DEF_MS;
            off_delay_q <= `OFF_DELAY_DEF;
        end
        else
        begin
            WB_ACK_O <= wb_req;
            if (wb_req && !WB_WE_I)
                WB_DAT_O <= rd_d;
            if (wb_wr)
            begin
                case (WB_ADR_I)
                    `REG_CTRL:
                        ctrl_q <= merge(ctrl_q, WB_DAT_I, WB_SEL_I);
                    `REG_SAFE_HL:
                        safe_hl_q <= clamp(wb_win, `HL_MIN_MS,
                            `MUTE_MAX_MS);
                    `REG_SAFE_LH:
                        safe_lh_q <= clamp(wb_win, `LH_MIN_MS,
                            `MUTE_MAX_MS);
                    `REG_ONOFF_HL:
                        onoff_hl_q <= clamp(wb_win, `HL_MIN_MS,
                            `HL_MAX_MS);
                    `REG_ONOFF_LH:
                        onoff_lh_q <= clamp(wb_win, `LH_MIN_MS,
                            `LH_MAX_MS);
                    `REG_OFF_DELAY:
                        off_delay_q <= wb_win;
                    default:
                        ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

    wire [7:0] latch_mask  = ctrl_q[`CTRL_LATCH_LSB +: 8];
    wire [7:0] mute_mask   = ctrl_q[`CTRL_MUTE_LSB +: 8];
    wire       onoff_map   = ctrl_q[`CTRL_ONOFF_MAP];
    wire       mute_cfg    = ctrl_q[`CTRL_MUTE_CFG];
    wire       cancel_keep = ctrl_q[`CTRL_CANCEL_KEEP];

    // Debounce channels
    wire [N_CH-1:0]   raw = {SYSTEM_RECOVERY_IN, CANCEL_DELAY_IN,
                             MUTE_ENABLE_IN, MANUAL_RESET_IN, ONOFF_IN,
                             SAFETY_IN};
    wire [N_CH-1:0]   st;
    wire [N_CH-1:0]   flt;
    wire [N_CH*W-1:0] hl_all;
    wire [N_CH*W-1:0] lh_all;

    genvar i;
    generate
        for (i = 0; i < N_CH; i = i + 1)
        begin : g_ch
            reg  [W-1:0] cnt_q;
            reg  [1:0]   edges_q;
            reg          st_q;
            reg          pend_q;
            reg          raw_q;
            reg          flt_q;
            wire [W-1:0] win = st_q ? hl_all[i*W +: W] : lh_all[i*W +: W];
            wire [W:0]   cnt_nx = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};

            if (i < N_SAFE)
            begin : g_safe
                // Mute sensors keep the long limit, others are cut back
                assign hl_all[i*W +: W] = mute_mask[i] ? safe_hl_q :
                    clamp(safe_hl_q, `HL_MIN_MS, `HL_MAX_MS);
                assign lh_all[i*W +: W] = mute_mask[i] ? safe_lh_q :
                    clamp(safe_lh_q, `LH_MIN_MS, `LH_MAX_MS);
            end
            else if (i == CH_ONOFF)
            begin : g_onoff
                assign hl_all[i*W +: W] = onoff_hl_q;
                assign lh_all[i*W +: W] = onoff_lh_q;
            end
            else
            begin : g_fixed
                assign hl_all[i*W +: W] = `FIXED_DB_MS;
                assign lh_all[i*W +: W] = `FIXED_DB_MS;
            end

            always @(posedge CLOCK)
            begin
                if (SRST)
                begin
                    cnt_q   <= {W{1'b0}};
                    edges_q <= 2'h0;
                    st_q    <= 1'b0;
                    pend_q  <= 1'b0;
                    raw_q   <= 1'b0;
                    flt_q   <= 1'b0;
                end
                else
                begin
                    raw_q <= raw[i];
                    flt_q <= 1'b0;
                    if (!pend_q)
                    begin
                        if (raw[i] != st_q)
                        begin
                            pend_q  <= 1'b1;
                            cnt_q   <= {W{1'b0}};
                            edges_q <= 2'h0;
                        end
                    end
                    else
                    begin
                        if (raw[i] != raw_q && edges_q != 2'h3)
                            edges_q <= edges_q + 2'h1;
                        if (tick_q)
                            cnt_q <= cnt_nx[W-1:0];
                        if (tick_q && cnt_nx >= {1'b0, win})
                        begin
                            pend_q <= 1'b0;
                            if (raw[i] != st_q)
                                st_q <= raw[i];
                            else if (edges_q >= 2'h2)
                                flt_q <= 1'b1;
                        end
                    end
                end
            end

            assign st[i]  = st_q;
            assign flt[i] = flt_q;
        end
    endgenerate

    // Reset pulse qualification: index 0 manual, 1 system
    wire [1:0] rst_lvl    = {st[CH_SYSR], st[CH_MRST]};
    wire [1:0] rst_nonmon = {ctrl_q[`CTRL_SRST_NONMON],
                             ctrl_q[`CTRL_MRST_NONMON]};
    wire [1:0] rst_ok;

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : g_rst
            reg  [W-1:0] dur_q;
            reg          hi_q;
            reg          done_q;
            reg          ok_q;

            always @(posedge CLOCK)
            begin
                if (SRST)
                begin
                    dur_q  <= {W{1'b0}};
                    hi_q   <= 1'b0;
                    done_q <= 1'b0;
                    ok_q   <= 1'b0;
                end
                else
                begin
                    hi_q <= rst_lvl[k];
                    ok_q <= 1'b0;
                    if (rst_lvl[k] && !hi_q)
                    begin
                        dur_q  <= {W{1'b0}};
                        done_q <= 1'b0;
                    end
                    else if (rst_lvl[k] && tick_q && dur_q != {W{1'b1}})
                        dur_q <= dur_q + {{(W-1){1'b0}}, 1'b1};
                    if (rst_nonmon[k] && rst_lvl[k] && hi_q && !done_q
                        && dur_q >= `RST_MIN_MS)
                    begin
                        ok_q   <= 1'b1;
                        done_q <= 1'b1;
                    end
                    if (!rst_nonmon[k] && !rst_lvl[k] && hi_q
                        && dur_q >= `RST_MIN_MS && dur_q <= `RST_MAX_MS)
                        ok_q <= 1'b1;
                end
            end

            assign rst_ok[k] = ok_q;
        end
    endgenerate

    // Output gating
    wire [N_SAFE-1:0] safe_st    = st[N_SAFE-1:0];
    wire              all_run    = &safe_st;
    wire              latch_stop = |(~safe_st & latch_mask[N_SAFE-1:0]);
    wire              onoff_st   = st[CH_ONOFF];
    wire              cancel_st  = st[CH_CANCEL];
    reg               need_q;
    reg               hold_q;
    reg               fault_q;
    reg  [W-1:0]      dly_q;
    wire              run_ok;

    // Unmapped ON/OFF input cannot veto the output
    assign run_ok = all_run & ~need_q & ~LOCKOUT & ~hold_q
                  & (~onoff_map | onoff_st);

    always @(posedge CLOCK)
    begin
        if (SRST)
        begin
            need_q           <= 1'b0;
            hold_q           <= 1'b0;
            fault_q          <= 1'b0;
            dly_q            <= {W{1'b0}};
            LOCKOUT          <= 1'b0;
            SAFETY_OUT       <= 1'b0;
            ONOFF_STATUS     <= 1'b0;
            MUTE_PERMIT      <= 1'b0;
            CANCEL_OK_STATUS <= 1'b0;
        end
        else
        begin
            // Set wins over clear on every sticky flag
            if (latch_stop)
                need_q <= 1'b1;
            else if (rst_ok[0] && all_run)
                need_q <= 1'b0;
            if (|flt[N_SAFE-1:0])
            begin
                LOCKOUT <= 1'b1;
                fault_q <= 1'b1;
            end
            else if (rst_ok[1])
                LOCKOUT <= 1'b0;
            if (ctrl_wr)
                hold_q <= 1'b1;
            else if (rst_ok[1])
                hold_q <= 1'b0;
            if (run_ok)
            begin
                SAFETY_OUT <= 1'b1;
                dly_q      <= {W{1'b0}};
            end
            else if (LOCKOUT || hold_q || !SAFETY_OUT)
                SAFETY_OUT <= 1'b0;
            else if (cancel_st && !cancel_keep)
                SAFETY_OUT <= 1'b0;
            else if (cancel_st)
                dly_q <= {W{1'b0}};
            else if (dly_q >= off_delay_q)
                SAFETY_OUT <= 1'b0;
            else if (tick_q)
                dly_q <= dly_q + {{(W-1){1'b0}}, 1'b1};
            ONOFF_STATUS     <= onoff_st;
            MUTE_PERMIT      <= ~mute_cfg | st[CH_MUTE];
            CANCEL_OK_STATUS <= SAFETY_OUT & ~run_ok & cancel_keep
                              & ~LOCKOUT & ~hold_q;
        end
    end

    assign status_w = {8'h00, {(8-N_SAFE){1'b0}}, safe_st,
                       8'h00, fault_q, MUTE_PERMIT, CANCEL_OK_STATUS,
                       onoff_st, need_q, hold_q, LOCKOUT, SAFETY_OUT};

endmodule

// ### verif/safety_input_debounce_reset_chk.sv
// Port checker for the safety input qualification block.
// Assumes the bus master writes CTRL with byte lane 2 enabled.
`timescale 1ns/1ps
module safety_input_debounce_reset_chk #(
    parameter N_SAFE      = 4,
    parameter TICK_CYCLES = 50000
) (
    input wire              CLOCK,
    input wire              SRST,
    input wire [7:0]        WB_ADR_I,
    input wire [31:0]       WB_DAT_I,
    input wire [31:0]       WB_DAT_O,
    input wire              WB_WE_I,
    input wire [3:0]        WB_SEL_I,
    input wire              WB_STB_I,
    input wire              WB_CYC_I,
    input wire              WB_ACK_O,
    input wire [N_SAFE-1:0] SAFETY_IN,
    input wire              ONOFF_IN,
    input wire              MANUAL_RESET_IN,
    input wire              MUTE_ENABLE_IN,
    input wire              CANCEL_DELAY_IN,
    input wire              SYSTEM_RECOVERY_IN,
    input wire              SAFETY_OUT,
    input wire              ONOFF_STATUS,
    input wire              MUTE_PERMIT,
    input wire              CANCEL_OK_STATUS,
    input wire              LOCKOUT
);
    // Shadow of CTRL[18:16]; age keeps checks off while a write settles
    reg  [2:0] cfg_q;
    reg  [1:0] age_q;
    wire       ctrl_wr;
    assign ctrl_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
                     && WB_SEL_I[2] && WB_ADR_I == 8'h00;
    always @(posedge CLOCK)
    begin
        if (SRST || ctrl_wr)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
        if (SRST)
            cfg_q <= 3'h0;
        else if (ctrl_wr)
            cfg_q <= WB_DAT_I[18:16];
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    a_ack_follows_req: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_unmapped_reads_zero: assert property (
        WB_ACK_O && !WB_WE_I && WB_ADR_I > 8'h18 |-> WB_DAT_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_lockout_drops_out: assert property (
        LOCKOUT |-> ##1 !SAFETY_OUT)
        else $error("output on during lockout");
    a_ctrl_write_holds: assert property (
        ctrl_wr |-> ##1 (!SAFETY_OUT) [*8])
        else $error("output on after config change");
    a_rise_not_locked: assert property (
        $rose(SAFETY_OUT) |-> !LOCKOUT)
        else $error("output rose while locked out");
    a_rise_needs_onoff: assert property (
        $rose(SAFETY_OUT) && cfg_q[0] && age_q == 2'h3 |-> ONOFF_STATUS)
        else $error("mapped output rose with on/off in stop");
    a_mute_free_unconfigured: assert property (
        age_q == 2'h3 && !cfg_q[1] |-> MUTE_PERMIT)
        else $error("muting blocked without mute enable config");
    a_cancel_ok_keep: assert property (
        age_q == 2'h3 && CANCEL_OK_STATUS |-> cfg_q[2])
        else $error("cancel status without keep option");
    c_lockout: cover property ($rose(LOCKOUT));
    c_mapped_on: cover property ($rose(SAFETY_OUT) && cfg_q[0]);
    c_cancel_ok: cover property ($rose(CANCEL_OK_STATUS));
endmodule

bind safety_input_debounce_reset safety_input_debounce_reset_chk #(
    .N_SAFE(N_SAFE), .TICK_CYCLES(TICK_CYCLES)) i_chk (
    .CLOCK(CLOCK), .SRST(SRST), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
    .WB_SEL_I(WB_SEL_I), .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I),
    .WB_ACK_O(WB_ACK_O), .SAFETY_IN(SAFETY_IN), .ONOFF_IN(ONOFF_IN),
    .MANUAL_RESET_IN(MANUAL_RESET_IN), .MUTE_ENABLE_IN(MUTE_ENABLE_IN),
    .CANCEL_DELAY_IN(CANCEL_DELAY_IN),
    .SYSTEM_RECOVERY_IN(SYSTEM_RECOVERY_IN), .SAFETY_OUT(SAFETY_OUT),
    .ONOFF_STATUS(ONOFF_STATUS), .MUTE_PERMIT(MUTE_PERMIT),
    .CANCEL_OK_STATUS(CANCEL_OK_STATUS), .LOCKOUT(LOCKOUT));

// ### verif/field_model.sv
// Field switches and sensors, 24 V levels seen as logic levels.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
module field_model #(
    parameter TK = 5
) (
    input  wire       clk,
    output reg  [3:0] safe,
    output reg  [4:0] sw
);
    // sw: on/off, manual reset, mute enable, cancel, recovery
    initial
    begin
        safe = 4'hF;
        sw = 5'h00;
    end
    task put_safe(input [3:0] v);
        begin
            safe <= v;
        end
    endtask
    task put_sw(input [4:0] m, input v);
        begin
            sw <= v ? (sw | m) : (sw & ~m);
        end
    endtask
    // Low-high-low press with a high phase of ms milliseconds
    task hold(input [4:0] m, input integer ms);
        begin
            put_sw(m, 1'b1);
            repeat (ms * TK) @(posedge clk);
            put_sw(m, 1'b0);
        end
    endtask
    // Contact chatter ending at its old level well inside one window
    task chatter(input integer k);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                safe[k] <= ~safe[k];
                repeat (3) @(posedge clk);
            end
        end
    endtask
endmodule

// ### verif/safety_input_debounce_reset_test.sv
// Self-checking bench: Wishbone master plus field device model.
// Runs with a 5-cycle millisecond tick to keep the run short.
`timescale 1ns/1ps
module safety_input_debounce_reset_test;
    localparam TK = 5;
    localparam ONF = 5'h01, MRS = 5'h02, MUT = 5'h04;
    localparam CAN = 5'h08, REC = 5'h10;
    reg         clk, srst, cs, we;
    reg  [7:0]  adr;
    reg  [31:0] wdat, rd;
    reg  [3:0]  sel;
    reg  [15:0] v;
    wire [31:0] rdat;
    wire        ack, out, lock, ons, mp, cok;
    wire [3:0]  safe;
    wire [4:0]  sw;
    integer     err_count, samples_checked, seed, tn;
    safety_input_debounce_reset #(.N_SAFE(4), .TICK_CYCLES(TK))
    i_safety_input_debounce_reset (
        .CLOCK(clk), .SRST(srst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(cs),
        .WB_CYC_I(cs), .WB_ACK_O(ack), .SAFETY_IN(safe),
        .ONOFF_IN(sw[0]), .MANUAL_RESET_IN(sw[1]), .MUTE_ENABLE_IN(sw[2]),
        .CANCEL_DELAY_IN(sw[3]), .SYSTEM_RECOVERY_IN(sw[4]),
        .SAFETY_OUT(out), .ONOFF_STATUS(ons), .MUTE_PERMIT(mp),
        .CANCEL_OK_STATUS(cok), .LOCKOUT(lock));
    field_model #(.TK(TK)) i_field_model (.clk(clk), .safe(safe), .sw(sw));
    always #10 clk = ~clk;
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e)
            begin
                err_count = err_count + 1;
                $display("MISMATCH %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            adr <= a;
            wdat <= d;
            we <= w;
            cs <= 1'b1;
            @(posedge clk);
            while (ack !== 1'b1)
                @(posedge clk);
            rd = rdat;
            cs <= 1'b0;
            we <= 1'b0;
            @(posedge clk);
        end
    endtask
    task wchk(input [7:0] a, input [15:0] w, input [15:0] e);
        begin
            bus(1'b1, a, {16'h0000, w});
            bus(1'b0, a, 32'h0000_0000);
            chk(rd, {16'h0000, e});
        end
    endtask
    task ms(input integer n);
        begin
            repeat (n * TK) @(posedge clk);
        end
    endtask
    task tend;
        begin
            tn = tn + 1;
            $display("test %0d done", tn);
        end
    endtask
    // CTRL writes hold the output off until a valid recovery press
    task cfg(input [31:0] v);
        begin
            bus(1'b1, 8'h00, v);
            bus(1'b0, 8'h18, 32'h0000_0000);
            chk(rd[2], 1'b1);
            i_field_model.hold(REC, 500);
            ms(60);
        end
    endtask
    initial
    begin
        #1_400_000;
        err_count = err_count + 1;
        final_report;
    end
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        cs = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        sel = 4'hF;
        err_count = 0;
        samples_checked = 0;
        seed = 23;
        tn = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        bus(1'b0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_0032);
        bus(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, 8'h1C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wchk(8'h04, 16'h0002, 16'h0006);
        wchk(8'h04, 16'h0640, 16'h05DC);
        v = 16'(16'h0006 + {$random(seed)} % 95);
        wchk(8'h04, v, v);
        // Only byte lane 1 written: lane 0 keeps the random window
        sel <= 4'h2;
        bus(1'b1, 8'h04, 32'h0000_0300);
        sel <= 4'hF;
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0300 + v);
        wchk(8'h08, 16'h0003, 16'h000A);
        wchk(8'h08, 16'h07D0, 16'h05DC);
        wchk(8'h0C, 16'h00C8, 16'h0064);
        wchk(8'h10, 16'h0258, 16'h01F4);
        wchk(8'h10, 16'h0005, 16'h000A);
        wchk(8'h04, 16'h0006, 16'h0006);
        wchk(8'h08, 16'h0032, 16'h0032);
        wchk(8'h0C, 16'h0006, 16'h0006);
        wchk(8'h10, 16'h0032, 16'h0032);
        tend;
        ms(60);
        chk(out, 1'b1);
        i_field_model.put_safe(4'hB);
        ms(5);
        chk(out, 1'b1);
        ms(3);
        chk(out, 1'b0);
        i_field_model.put_safe(4'hF);
        ms(48);
        chk(out, 1'b0);
        ms(4);
        chk(out, 1'b1);
        i_field_model.chatter(3);
        ms(10);
        chk(lock, 1'b1);
        chk(out, 1'b0);
        i_field_model.hold(REC, 500);
        ms(60);
        chk(lock, 1'b0);
        chk(out, 1'b1);
        tend;
        cfg(32'h0000_0001);
        chk(out, 1'b1);
        i_field_model.put_safe(4'hE);
        ms(10);
        chk(out, 1'b0);
        i_field_model.hold(MRS, 500);
        ms(60);
        i_field_model.put_safe(4'hF);
        ms(60);
        chk(out, 1'b0);
        i_field_model.hold(MRS, 200);
        ms(60);
        chk(out, 1'b0);
        i_field_model.hold(MRS, 2500);
        ms(60);
        chk(out, 1'b0);
        i_field_model.hold(MRS, 400 + {$random(seed)} % 1400);
        chk(out, 1'b0);
        ms(60);
        chk(out, 1'b1);
        tend;
        cfg(32'h0008_0001);
        i_field_model.put_safe(4'hE);
        ms(10);
        i_field_model.put_safe(4'hF);
        ms(60);
        i_field_model.put_sw(MRS, 1'b1);
        ms(320);
        chk(out, 1'b0);
        ms(40);
        chk(out, 1'b1);
        i_field_model.put_sw(MRS, 1'b0);
        tend;
        cfg(32'h0003_0000);
        chk(out, 1'b0);
        chk(mp, 1'b0);
        i_field_model.put_sw(ONF | MUT, 1'b1);
        ms(60);
        chk(out, 1'b1);
        chk(mp, 1'b1);
        i_field_model.put_sw(ONF, 1'b0);
        ms(8);
        chk(out, 1'b0);
        cfg(32'h0000_0000);
        chk(out, 1'b1);
        chk(ons, 1'b0);
        tend;
        bus(1'b1, 8'h14, 32'h0000_00C8);
        cfg(32'h0004_0000);
        i_field_model.put_safe(4'hD);
        ms(10);
        chk(out, 1'b1);
        chk(cok, 1'b1);
        i_field_model.put_sw(CAN, 1'b1);
        ms(250);
        chk(out, 1'b1);
        i_field_model.put_sw(CAN, 1'b0);
        i_field_model.put_safe(4'hF);
        cfg(32'h0000_0000);
        i_field_model.put_safe(4'hD);
        ms(10);
        chk(cok, 1'b0);
        i_field_model.put_sw(CAN, 1'b1);
        ms(60);
        chk(out, 1'b0);
        tend;
        final_report;
    end
endmodule
